/* rtl/fcr_regs.svh */
`ifndef FCR_REGS_SVH
`define FCR_REGS_SVH
`define FCR_ADDR_W          8
`define FCR_OFS_FUSE_CTL    8'h29
`define FCR_OFS_RESET_CTL   8'h2a
`define FCR_OFS_IRQ0_MAP0   8'h2b
`define FCR_OFS_SECONDARY_STATUS_REGISTER     8'h10
`define FCR_OFS_DEV_CTL     8'h11
`define FCR_RST_FUSE_CTL    8'h00
`define FCR_RST_RESET_CTL   8'h00
`define FCR_RST_IRQ0_MAP0   8'h80
`define FCR_RST_DEV_CTL     8'h00
`define FCR_BIT_ECC_START   7
`define FCR_BIT_CRC_START   3
`define FCR_BIT_SOFT_RESET  1
`define FCR_BIT_BUSY_MAP    7
`define FCR_BIT_INACT_MAP   6
`define FCR_BIT_ACT_MAP     5
`define FCR_BIT_ECC_ERR     1
`define FCR_BIT_CRC_ERR     0
`define FCR_RESET_KEY       8'h52
`define FCR_ECC_CYCLES      8'd7
`define FCR_CRC_CYCLES      8'd3
`define FCR_CLK_MHZ         250
`define FCR_INIT_TIME_US    500
`endif

/* rtl/fcr_pkg.sv */
`default_nettype none
package fcr_pkg;
    typedef enum logic [3:0] {
        FCR_IDLE = 4'b0001,
        FCR_ECC  = 4'b0010,
        FCR_CRC  = 4'b0100,
        FCR_LOAD = 4'b1000
    } fcr_fuse_state_e;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } fcr_bus_req_s;
endpackage : fcr_pkg
`default_nettype wire

/* rtl/fcr_fuse_ctrl.sv */
// The plain strobed port was chosen for this implementation.
`include "fcr_regs.svh"
`default_nettype none
module fcr_fuse_ctrl
    import fcr_pkg::*;
#(
    parameter int INIT_CYCLES = `FCR_CLK_MHZ * `FCR_INIT_TIME_US
) (
    input  wire logic       ref_clk,
    input  wire logic       srst,
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output logic      [7:0] reg_rdata,
    input  wire logic       ecc_fault,
    input  wire logic       crc_fault,
    input  wire logic       inactivity_flag,
    input  wire logic       activity_flag,
    output logic            interrupt_pin_zero_o,
    output logic            interrupt_pin_zero_oe,
    output logic            interrupt_pin_one_oe,
    output logic            sensor_standby,
    output logic            fuse_busy_flag,
    output logic            soft_reset_pulse
);

    // ------------------------------------------------------------
    // Bus request and decode
    // ------------------------------------------------------------
    fcr_bus_req_s req;
    assign req = '{wr: reg_wr, rd: reg_rd, addr: reg_addr, wdata: reg_wdata};

    function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
        return a == ofs;
    endfunction : hit

    localparam int CNT_W = $clog2(INIT_CYCLES + 1);

    logic [7:0]           fuse_ctl_q;
    logic [7:0]           irq0_map0_q;
    logic [7:0]           secondary_status_register_q;
    logic [7:0]           dev_ctl_q;
    logic [CNT_W-1:0]     init_cnt_q;
    logic                 init_busy;
    logic                 key_hit;
    logic                 soft_rst;
    logic [7:0]           fuse_cnt_q;
    fcr_fuse_state_e      state_q;

    assign init_busy = init_cnt_q != '0;
    assign key_hit   = req.wr && hit(req.addr, `FCR_OFS_RESET_CTL)
                       && req.wdata == `FCR_RESET_KEY;
    // Reset bit reads zero, so each key write is a 0-to-1 event
    assign soft_rst  = key_hit;
    assign soft_reset_pulse = soft_rst;

    // ------------------------------------------------------------
    // Initialization window after soft reset
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            init_cnt_q <= '0;
        end else if (soft_rst) begin
            init_cnt_q <= CNT_W'(INIT_CYCLES);
        end else if (init_busy) begin
            init_cnt_q <= init_cnt_q - CNT_W'(1);
        end
    end

    // ------------------------------------------------------------
    // Writable registers
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (srst || soft_rst) begin
            fuse_ctl_q  <= `FCR_RST_FUSE_CTL;
            irq0_map0_q <= `FCR_RST_IRQ0_MAP0;
            dev_ctl_q   <= `FCR_RST_DEV_CTL;
        end else begin
            if (req.wr && !init_busy && hit(req.addr, `FCR_OFS_FUSE_CTL)) begin
                fuse_ctl_q <= req.wdata;
            end else if (state_q != FCR_IDLE && fuse_cnt_q == 8'd1) begin
                // Start bit self-clears when the check ends
                if (state_q == FCR_ECC) begin
                    fuse_ctl_q[`FCR_BIT_ECC_START] <= 1'b0;
                end
                if (state_q == FCR_CRC) begin
                    fuse_ctl_q[`FCR_BIT_CRC_START] <= 1'b0;
                end
            end
            if (req.wr && !init_busy && hit(req.addr, `FCR_OFS_IRQ0_MAP0)) begin
                irq0_map0_q <= req.wdata;
            end
            if (req.wr && !init_busy && hit(req.addr, `FCR_OFS_DEV_CTL)) begin
                dev_ctl_q <= req.wdata;
            end
        end
    end

    // ------------------------------------------------------------
    // Fuse controller
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            state_q    <= FCR_IDLE;
            fuse_cnt_q <= 8'd0;
        end else if (soft_rst) begin
            state_q    <= FCR_LOAD;
            fuse_cnt_q <= `FCR_ECC_CYCLES;
        end else begin
            case (state_q)
                FCR_IDLE: begin
                    if (fuse_ctl_q[`FCR_BIT_ECC_START]) begin
                        state_q    <= FCR_ECC;
                        fuse_cnt_q <= `FCR_ECC_CYCLES;
                    end else if (fuse_ctl_q[`FCR_BIT_CRC_START]) begin
                        state_q    <= FCR_CRC;
                        fuse_cnt_q <= `FCR_CRC_CYCLES;
                    end else begin
                        state_q    <= FCR_IDLE;
                    end
                end
                FCR_ECC, FCR_CRC, FCR_LOAD: begin
                    if (fuse_cnt_q <= 8'd1) begin
                        state_q    <= FCR_IDLE;
                        fuse_cnt_q <= 8'd0;
                    end else begin
                        fuse_cnt_q <= fuse_cnt_q - 8'd1;
                    end
                end
                default: begin
                    state_q    <= FCR_IDLE;
                    fuse_cnt_q <= 8'd0;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Secondary status: check results
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (srst || soft_rst) begin
            secondary_status_register_q <= 8'h00;
        end else if (state_q == FCR_ECC && fuse_cnt_q == 8'd1) begin
            secondary_status_register_q[`FCR_BIT_ECC_ERR] <= ecc_fault;
        end else if (state_q == FCR_CRC && fuse_cnt_q == 8'd1) begin
            secondary_status_register_q[`FCR_BIT_CRC_ERR] <= crc_fault;
        end
    end

    assign fuse_busy_flag = state_q != FCR_IDLE;

    // ------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            reg_rdata <= 8'h00;
        end else if (!req.rd || init_busy || soft_rst) begin
            reg_rdata <= 8'h00;
        end else begin
            case (req.addr)
                `FCR_OFS_FUSE_CTL:  reg_rdata <= fuse_ctl_q;
                `FCR_OFS_RESET_CTL: reg_rdata <= 8'h00;
                `FCR_OFS_IRQ0_MAP0: reg_rdata <= irq0_map0_q;
                `FCR_OFS_SECONDARY_STATUS_REGISTER:   reg_rdata <= secondary_status_register_q;
                `FCR_OFS_DEV_CTL:   reg_rdata <= dev_ctl_q;
                default:            reg_rdata <= 8'h00;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Interrupt pin 0 and pin drive
    // ------------------------------------------------------------
    logic irq0_d;
    always_comb begin
        irq0_d = (irq0_map0_q[`FCR_BIT_BUSY_MAP]  && fuse_busy_flag)
              || (irq0_map0_q[`FCR_BIT_INACT_MAP] && inactivity_flag)
              || (irq0_map0_q[`FCR_BIT_ACT_MAP]   && activity_flag);
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            interrupt_pin_zero_o <= 1'b0;
        end else begin
            interrupt_pin_zero_o <= irq0_d;
        end
    end

    // Pins float in the key-write cycle and the init window, driven otherwise
    assign interrupt_pin_zero_oe = !init_busy && !soft_rst;
    assign interrupt_pin_one_oe  = !init_busy && !soft_rst;
    // Sensors in standby until software sets device control bit 0
    assign sensor_standby = !dev_ctl_q[0];

endmodule : fcr_fuse_ctrl
`default_nettype wire

/* test/fcr_chk_properties.sv */
`default_nettype none
module fcr_chk_properties #(
    parameter int INIT_CYCLES = 125000
) (
    input wire logic       ref_clk,
    input wire logic       srst,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic       reg_wr,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic       inactivity_flag,
    input wire logic       activity_flag,
    input wire logic       interrupt_pin_zero_o,
    input wire logic       interrupt_pin_zero_oe,
    input wire logic       interrupt_pin_one_oe,
    input wire logic       sensor_standby,
    input wire logic       fuse_busy_flag,
    input wire logic       soft_reset_pulse
);
    timeunit 1ns;
    timeprecision 1ps;
    // ----
    // Shadow of the pin 0 map
    // ----
    logic [7:0] map_q;
    wire logic  key_wr = reg_wr && reg_addr == 8'h2a && reg_wdata == 8'h52;
    wire logic  go_ok = interrupt_pin_zero_oe && !fuse_busy_flag && reg_wr && reg_addr == 8'h29;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (srst);
    always_ff @(posedge ref_clk) begin
        if (srst || soft_reset_pulse) begin
            map_q <= 8'h80;
        end else if (reg_wr && reg_addr == 8'h2b && interrupt_pin_zero_oe) begin
            map_q <= reg_wdata;
        end
    end
    sequence ecc_go;
        go_ok && reg_wdata == 8'h80;
    endsequence
    sequence crc_go;
        go_ok && reg_wdata == 8'h08;
    endsequence
    AST_KEY_PULSE: assert property (key_wr |-> soft_reset_pulse)
        else $error("key write gave no reset pulse");
    AST_PULSE_CAUSE: assert property (soft_reset_pulse |-> key_wr)
        else $error("reset pulse without key write");
    AST_PINS_FLOAT: assert property (
        soft_reset_pulse |-> !interrupt_pin_zero_oe && !interrupt_pin_one_oe)
        else $error("pins driven in reset cycle");
    AST_STANDBY: assert property (
        soft_reset_pulse |=> sensor_standby ##[0:2] fuse_busy_flag)
        else $error("no standby or reload after reset");
    AST_INIT_ZERO: assert property (
        !interrupt_pin_zero_oe && reg_rd |=> reg_rdata == 8'h00)
        else $error("nonzero read in init window");
    AST_ECC_RUN: assert property (ecc_go |-> ##2 fuse_busy_flag [*7] ##1 !fuse_busy_flag)
        else $error("ecc check length wrong");
    AST_CRC_RUN: assert property (crc_go |-> ##2 fuse_busy_flag [*3] ##1 !fuse_busy_flag)
        else $error("crc check length wrong");
    AST_IRQ_MAP: assert property (
        interrupt_pin_zero_o ==
        $past(|(map_q[7:5] & {fuse_busy_flag, inactivity_flag, activity_flag})))
        else $error("pin 0 not the mapped sources");
endmodule : fcr_chk_properties
bind fcr_fuse_ctrl fcr_chk_properties #(.INIT_CYCLES(INIT_CYCLES)) i_fcr_chk_properties (.*);
`default_nettype wire

/* test/fcr_host_model.sv */
`default_nettype none
module fcr_host_model (
    input  wire logic       ref_clk,
    input  wire logic [7:0] reg_rdata,
    output logic      [7:0] reg_addr,
    output logic      [7:0] reg_wdata,
    output logic            reg_wr,
    output logic            reg_rd
);
    timeunit 1ns;
    timeprecision 1ps;
    // ----
    // Host bus cycles
    // ----
    initial begin
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
    end
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
        reg_addr <= ~a;
        reg_wdata <= ~d;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge ref_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        reg_addr <= ~a;
        // Data stand only in the cycle after the strobe
        @(posedge ref_clk);
        d = reg_rdata;
    endtask : rd
endmodule : fcr_host_model
`default_nettype wire

/* test/tb_top.sv */
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk, srst, ecc_fault, crc_fault, inactivity_flag, activity_flag, reg_wr, reg_rd;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, rv;
    logic interrupt_pin_zero_o, interrupt_pin_zero_oe, interrupt_pin_one_oe;
    logic sensor_standby, fuse_busy_flag, soft_reset_pulse;
    int   mismatches = 0;
    int   n_compared = 0;
    fcr_host_model i_fcr_host_model (.*);
    fcr_fuse_ctrl #(.INIT_CYCLES(20)) i_fcr_fuse_ctrl (.*);
    initial begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end
    // ----
    // Checking helpers
    // ----
    task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
        n_compared++;
        if (s !== e) begin
            mismatches++;
            $display("mismatch %s exp %h seen %h", n, e, s);
        end
    endtask : chk
    task automatic cr(input string n, input logic [7:0] a, input logic [7:0] e);
        i_fcr_host_model.rd(a, rv);
        chk(n, rv, e);
    endtask : cr
    task automatic pin(input string n, input logic e);
        repeat (4) @(negedge ref_clk);
        chk(n, {7'h00, interrupt_pin_zero_o}, {7'h00, e});
    endtask : pin
    task automatic wait_idle();
        repeat (2) @(posedge ref_clk);
        for (int i = 0; i < 40 && fuse_busy_flag !== 1'b0; i++) @(posedge ref_clk);
        if (fuse_busy_flag !== 1'b0) begin
            mismatches++;
            end_of_test();
        end
    endtask : wait_idle
    task automatic end_of_test();
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : end_of_test
    // ----
    // Scenarios
    // ----
    task automatic t_checks();
        ecc_fault <= 1'b1;
        i_fcr_host_model.wr(8'h29, 8'h80);
        pin("busy_irq", 1'b1);
        wait_idle();
        cr("ecc_err", 8'h10, 8'h02);
        @(posedge ref_clk);
        ecc_fault <= 1'b0;
        crc_fault <= 1'b1;
        i_fcr_host_model.wr(8'h29, 8'h08);
        wait_idle();
        cr("crc_err", 8'h10 & 8'hff, 8'h02 | 8'h01);
        i_fcr_host_model.wr(8'h29, 8'h00);
        repeat (10) @(negedge ref_clk);
        chk("idle_busy", {7'h00, fuse_busy_flag}, 8'h00);
    endtask : t_checks
    task automatic t_map();
        i_fcr_host_model.wr(8'h2b, 8'h40);
        inactivity_flag <= 1'b1;
        pin("inact_on", 1'b1);
        i_fcr_host_model.wr(8'h2b, 8'h00);
        pin("inact_off", 1'b0);
        i_fcr_host_model.wr(8'h2b, 8'h20);
        activity_flag <= 1'b1;
        pin("act_on", 1'b1);
    endtask : t_map
    task automatic t_soft();
        i_fcr_host_model.wr(8'h11, 8'h01);
        @(negedge ref_clk);
        chk("standby_off", {7'h00, sensor_standby}, 8'h00);
        i_fcr_host_model.wr(8'h2a, 8'h52);
        @(negedge ref_clk);
        chk("oe_float", {6'h00, interrupt_pin_zero_oe, interrupt_pin_one_oe}, 8'h00);
        cr("init_read", 8'h2b, 8'h00);
        i_fcr_host_model.wr(8'h2b, 8'h20);
        repeat (30) @(posedge ref_clk);
        cr("map_dflt", 8'h2b, 8'h80);
        chk("standby", {7'h00, sensor_standby}, 8'h01);
        chk("oe_back", {6'h00, interrupt_pin_zero_oe, interrupt_pin_one_oe}, 8'h03);
        pin("act_unmapped", 1'b0);
    endtask : t_soft
    initial begin
        srst = 1'b1;
        {ecc_fault, crc_fault, inactivity_flag, activity_flag} = 4'h0;
        repeat (5) @(posedge ref_clk);
        srst <= 1'b0;
        cr("ctl_rst", 8'h29, 8'h00);
        cr("key_rst", 8'h2a, 8'h00);
        cr("map_rst", 8'h2b, 8'h80);
        cr("unmapped", 8'h3f, 8'h00);
        t_checks();
        t_map();
        t_soft();
        end_of_test();
    end
endmodule : tb_top
`default_nettype wire
